// *** core/charge_current_config_regs.vh ***
// Register offsets, field positions, reset values and decode steps.
`ifndef CHARGE_CURRENT_CONFIG_REGS_VH
`define CHARGE_CURRENT_CONFIG_REGS_VH

// Serial bus slave address, seven bits.
`define SLAVE_ADDR 7'h6b
// Highest writable register offset in the whole bank.
`define LAST_RW_OFFSET 8'h07
`define LAST_RO_OFFSET 8'h0a

// Register offsets.
`define FAST_CHARGE_CURRENT_CTRL_OFS 8'h02
`define PRECHARGE_TERMINATION_CURRENT_CTRL_OFS 8'h03

// Reset values.
`define FAST_CHARGE_CURRENT_CTRL_RST 8'h60
`define PRECHARGE_TERMINATION_CURRENT_CTRL_RST 8'h11

// Field positions in the fast-charge control register.
`define FAST_LIMIT_MSB 7
`define FAST_LIMIT_LSB 2
`define RESERVED_BIT 1
`define REDUCTION_BIT 0

// Field positions in the pre-charge and termination register.
`define PRE_LIMIT_MSB 7
`define PRE_LIMIT_LSB 4
`define TERM_LIMIT_MSB 3
`define TERM_LIMIT_LSB 0

// Decode offsets and step sizes in mA.
`define FAST_OFFSET_MA 13'h0200
`define FAST_STEP_MA 13'h0040
`define PRE_TERM_OFFSET_MA 13'h0080
`define PRE_TERM_STEP_MA 13'h0080
// Upper ends of the fast-charge range for the two variants, in mA.
`define FAST_MAX_HIGH_MA 13'h11c0
`define FAST_MAX_LOW_MA 13'h09c0
// Reduced fast-charge current is one fifth, pre-charge one half.
`define FAST_REDUCE_DIV 13'h0005

`endif

// *** core/charge_current_config.v ***
// Serial-bus register bank holding the charge current configuration.
`timescale 1ns/1ps
// Summary of operation
// - Fast-charge field bits 7:2 decode as 512 mA plus 64 mA steps.
// - Fast-charge limit capped at 4544 mA or 2496 mA by variant.
// - Fast-charge field resets to code 011000, which is 2048 mA.
// - Fast-charge control register resets to 8'h60, low two bits clear.
// - Reduction bit set: fast limit 20 percent, pre-charge 50 percent.
// - Reduction bit clear: programmed fast and pre-charge values used.
// - Pre-charge and termination fields decode 128 mA plus 128 mA steps.
// - Pre-charge and termination fields reset to 0001, which is 256 mA.
// - Pre-charge and termination register resets to 8'h11.
// - Bank answers serial address 6BH; 00-07 writable, 08-0A read only.
`include "charge_current_config_regs.vh"

module charge_current_config #(
	parameter HIGH_CURRENT_VARIANT = 1, // One for the higher-current part.
	parameter CUR_W = 13 // Width of the decoded currents in mA.
) (
	input wire sys_clk, // System clock, 100 MHz.
	input wire rstn, // Asynchronous reset, active low.
	input wire ce, // Clock enable; all state holds while low.
	input wire scl_in, // Serial clock level from the host.
	input wire sda_in, // Serial data level on the wire.
	output wire sda_out, // Serial data drive value, always low.
	output wire sda_oe, // High while the data line is pulled low.
	output reg [CUR_W-1:0] fast_charge_current_limit, // Effective fast mA.
	output reg [CUR_W-1:0] precharge_current_limit, // Effective pre mA.
	output reg [CUR_W-1:0] termination_current_limit, // Termination mA.
	output reg current_reduction_force // Reduction bit as stored.
);

	// One-hot states of the serial slave.
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_ADDR = 6'h02;
	localparam [5:0] ST_PTR = 6'h04;
	localparam [5:0] ST_WDATA = 6'h08;
	localparam [5:0] ST_RDATA = 6'h10;
	localparam [5:0] ST_SKIP = 6'h20;
	localparam [3:0] ACK_SLOT = 4'h8;
	localparam [3:0] ACK_DONE = 4'h9;

	// The serial pins are sampled once per system clock, so the host must
	// hold each serial clock level for a few system clocks. A data bit is
	// taken on the clock edge that first sees the serial clock high. The
	// data line is only ever pulled low, and only changes on the clock edge
	// that first sees a serial clock fall, so the slave never makes a false
	// start or stop of its own. A start or a stop seen anywhere aborts
	// the byte in progress and releases the data line at once.
	// The pointer persists between transactions, so a read may follow a
	// write of the pointer alone. Offsets outside the two registers are
	// acknowledged and read as zero, which keeps the host's byte count in
	// step with the rest of the bank even though those registers live
	// elsewhere.

	// Serial slave state and byte assembly.
	reg [5:0] state_reg;
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] tx_reg;

	// Register pointer, direction and the host's acknowledge.
	reg [7:0] ptr_reg;
	reg rw_reg;
	reg nack_reg;

	// Data line drive and the previous pin samples.
	reg drive_low_reg;
	reg scl_q_reg;
	reg sda_q_reg;

	// The two stored configuration registers, kept exactly as written.
	reg [7:0] fast_charge_current_ctrl_reg;
	reg [7:0] precharge_termination_current_ctrl_reg;

	// Pin events, pointer arithmetic and the bytes offered for reading.
	wire scl_rise;
	wire scl_fall;
	wire start_seen;
	wire stop_seen;
	wire [7:0] ptr_inc;
	wire [7:0] rd_cur;
	wire [7:0] rd_nxt;

	// Returns the register value at an offset; holes and others read zero.
	function [7:0] read_mux;
		input [7:0] ofs;
		input [7:0] fast_val;
		input [7:0] pre_val;
		begin
			read_mux = 8'h00;
			if (ofs == `FAST_CHARGE_CURRENT_CTRL_OFS) begin
				read_mux = fast_val;
			end else if (ofs == `PRECHARGE_TERMINATION_CURRENT_CTRL_OFS) begin
				read_mux = pre_val;
			end
		end
	endfunction

	// Decodes a four-bit field as offset plus binary-weighted steps.
	function [12:0] decode_pre_term;
		input [3:0] code;
		begin
			decode_pre_term = `PRE_TERM_OFFSET_MA +
				`PRE_TERM_STEP_MA * {9'h000, code};
		end
	endfunction

	// Edge and bus condition detection on the sampled pins.
	assign scl_rise = scl_in & ~scl_q_reg;
	assign scl_fall = ~scl_in & scl_q_reg;
	assign start_seen = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
	assign stop_seen = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
	assign ptr_inc = ptr_reg + 8'h01;

	// Byte at the pointer and at the next offset, for the read path.
	assign rd_cur = read_mux(ptr_reg, fast_charge_current_ctrl_reg,
		precharge_termination_current_ctrl_reg);
	assign rd_nxt = read_mux(ptr_inc, fast_charge_current_ctrl_reg,
		precharge_termination_current_ctrl_reg);

	// Open-drain drive: only ever pulls low.
	assign sda_out = 1'b0;
	assign sda_oe = drive_low_reg;

	// Keeps the previous pin samples for edge detection.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else if (ce) begin
			scl_q_reg <= scl_in;
			sda_q_reg <= sda_in;
		end
	end

	// Serial slave: address match, pointer, writes and auto-incrementing reads.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			rw_reg <= 1'b0;
			nack_reg <= 1'b0;
			drive_low_reg <= 1'b0;
			fast_charge_current_ctrl_reg <= `FAST_CHARGE_CURRENT_CTRL_RST;
			precharge_termination_current_ctrl_reg <=
				`PRECHARGE_TERMINATION_CURRENT_CTRL_RST;
		end else if (ce) begin
			if (start_seen) begin
				state_reg <= ST_ADDR;
				bit_cnt_reg <= 4'h0;
				drive_low_reg <= 1'b0;
			end else if (stop_seen) begin
				state_reg <= ST_IDLE;
				bit_cnt_reg <= 4'h0;
				drive_low_reg <= 1'b0;
			end else if (scl_rise) begin
				if (bit_cnt_reg < ACK_SLOT) begin
					shift_reg <= {shift_reg[6:0], sda_in};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else if (bit_cnt_reg == ACK_SLOT) begin
					nack_reg <= sda_in;
					bit_cnt_reg <= ACK_DONE;
				end
			end else if (scl_fall) begin
				if (bit_cnt_reg == ACK_SLOT) begin
					// Byte complete: acknowledge it or hand the line to the host.
					case (state_reg)
					// Address byte: answer only our own address.
					ST_ADDR: begin
						if (shift_reg[7:1] == `SLAVE_ADDR) begin
							drive_low_reg <= 1'b1;
							rw_reg <= shift_reg[0];
						end else begin
							state_reg <= ST_SKIP;
						end
					end
					// Pointer byte: any offset is taken and acknowledged.
					ST_PTR: begin
						ptr_reg <= shift_reg;
						drive_low_reg <= 1'b1;
					end
					// Data byte: store it if it hits one of our registers,
					// then step the pointer for a following byte.
					ST_WDATA: begin
						if (ptr_reg == `FAST_CHARGE_CURRENT_CTRL_OFS) begin
							fast_charge_current_ctrl_reg <= shift_reg;
						end
						if (ptr_reg == `PRECHARGE_TERMINATION_CURRENT_CTRL_OFS) begin
							precharge_termination_current_ctrl_reg <=
								shift_reg;
						end
						ptr_reg <= ptr_inc;
						drive_low_reg <= 1'b1;
					end
					ST_RDATA: begin
						drive_low_reg <= 1'b0;
					end
					default: begin
						drive_low_reg <= 1'b0;
					end
					endcase
				end else if (bit_cnt_reg == ACK_DONE) begin
					// Acknowledge clock over: set up the next byte.
					bit_cnt_reg <= 4'h0;
					drive_low_reg <= 1'b0;
					case (state_reg)
					ST_ADDR: begin
						if (rw_reg) begin
							// Read: load the byte and show its first bit.
							state_reg <= ST_RDATA;
							tx_reg <= rd_cur;
							drive_low_reg <= ~rd_cur[7];
						end else begin
							state_reg <= ST_PTR;
						end
					end
					ST_PTR: begin
						state_reg <= ST_WDATA;
					end
					ST_RDATA: begin
						if (nack_reg) begin
							state_reg <= ST_SKIP;
						end else begin
							// The host wants more: move on one offset.
							ptr_reg <= ptr_inc;
							tx_reg <= rd_nxt;
							drive_low_reg <= ~rd_nxt[7];
						end
					end
					default: begin
						state_reg <= state_reg;
					end
					endcase
				end else if (state_reg == ST_RDATA && bit_cnt_reg != 4'h0) begin
					// Present the next data bit, most significant first.
					tx_reg <= {tx_reg[6:0], 1'b0};
					drive_low_reg <= ~tx_reg[6];
				end
			end
		end
	end

	// The cap is applied before any reduction, so a stored code above the
	// variant's range still yields a legal current. The stored byte itself
	// is never altered, so the host reads back what it wrote.
	// Decoded, capped and reduced currents, registered for the charge loop.
	reg [12:0] fast_prog;
	reg [12:0] fast_cap;
	reg [12:0] pre_prog;
	always @* begin
		fast_prog = `FAST_OFFSET_MA + `FAST_STEP_MA * {7'h00,
			fast_charge_current_ctrl_reg[`FAST_LIMIT_MSB:`FAST_LIMIT_LSB]};
		fast_cap = (HIGH_CURRENT_VARIANT != 0) ? `FAST_MAX_HIGH_MA :
			`FAST_MAX_LOW_MA;
		if (fast_prog > fast_cap) begin
			fast_prog = fast_cap;
		end
		pre_prog = decode_pre_term(
			precharge_termination_current_ctrl_reg[`PRE_LIMIT_MSB:`PRE_LIMIT_LSB]);
	end

	// The reduction is an integer divide, so results round down.
	// Termination current is never reduced.
	// Output registers follow the stored fields one cycle after a write.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fast_charge_current_limit <= {CUR_W{1'b0}};
			precharge_current_limit <= {CUR_W{1'b0}};
			termination_current_limit <= {CUR_W{1'b0}};
			current_reduction_force <= 1'b0;
		end else if (ce) begin
			current_reduction_force <=
				fast_charge_current_ctrl_reg[`REDUCTION_BIT];
			if (fast_charge_current_ctrl_reg[`REDUCTION_BIT]) begin
				fast_charge_current_limit <=
					fast_prog / `FAST_REDUCE_DIV;
				precharge_current_limit <= {1'b0, pre_prog[12:1]};
			end else begin
				fast_charge_current_limit <= fast_prog;
				precharge_current_limit <= pre_prog;
			end
			termination_current_limit <= decode_pre_term(
				precharge_termination_current_ctrl_reg[`TERM_LIMIT_MSB:
				`TERM_LIMIT_LSB]);
		end
	end

endmodule // charge_current_config

// *** sim/charge_current_config_checker.sv ***
// Concurrent checks on the serial pins and decoded limits of the bank.
`timescale 1ns/1ps
module charge_current_config_checker #(
	parameter HIGH_CURRENT_VARIANT = 1, // Selects the fast cap.
	parameter CUR_W = 13 // Limit width.
) (
	input wire sys_clk, // Clock.
	input wire rstn, // Reset, active low.
	input wire scl_in, // Serial clock.
	input wire sda_oe, // Data pull-down.
	input wire [CUR_W-1:0] fast_charge_current_limit, // Fast mA.
	input wire [CUR_W-1:0] precharge_current_limit, // Pre mA.
	input wire [CUR_W-1:0] termination_current_limit, // Term mA.
	input wire current_reduction_force // Reduction bit.
);
	localparam int CAP = HIGH_CURRENT_VARIANT ? 4544 : 2496;
	wire [CUR_W-1:0] fast = fast_charge_current_limit;
	wire [CUR_W-1:0] pre = precharge_current_limit;
	wire [CUR_W-1:0] term = termination_current_limit;
	wire frc = current_reduction_force;
	reg [1:0] age_reg;
	wire live = age_reg != 2'h0;
	wire old = age_reg[1];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// Counts edges since reset, since limits settle one edge after release.
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			age_reg <= 2'h0;
		else if (age_reg != 2'h3)
			age_reg <= age_reg + 2'h1;
	end
	sequence oe_held_s;
		sda_oe [*3];
	endsequence
	fast_grid_a: assert property (
		live && !frc |-> fast[5:0] == 6'h00 && fast >= 13'h0200
		&& fast <= CAP) else $error("fast limit off its grid");
	pre_grid_a: assert property (
		live && !frc |-> pre[6:0] == 7'h00 && pre >= 13'h0080
		&& pre <= 13'h0800) else $error("pre limit off its grid");
	term_grid_a: assert property (
		live |-> term[6:0] == 7'h00 && term >= 13'h0080
		&& term <= 13'h0800) else $error("term limit off its grid");
	cut_range_a: assert property (
		live && frc |-> pre[5:0] == 6'h00 && pre <= 13'h0400
		&& fast >= 13'h0066 && fast <= CAP / 5) else $error("cut limits bad");
	term_kept_a: assert property (
		$changed(frc) |-> $stable(term)) else $error("term moved on cut");
	wr_update_a: assert property (
		old && !$stable({fast, term}) |-> sda_oe)
		else $error("limits moved outside a write");
	oe_move_a: assert property (
		$changed(sda_oe) |-> !scl_in) else $error("data moved, clock high");
	oe_stands_a: assert property (
		$rose(scl_in) && sda_oe |-> oe_held_s) else $error("data not held");
endmodule // charge_current_config_checker

bind charge_current_config charge_current_config_checker #(
	.HIGH_CURRENT_VARIANT(HIGH_CURRENT_VARIANT),
	.CUR_W(CUR_W)
) chk (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.scl_in(scl_in),
	.sda_oe(sda_oe),
	.fast_charge_current_limit(fast_charge_current_limit),
	.precharge_current_limit(precharge_current_limit),
	.termination_current_limit(termination_current_limit),
	.current_reduction_force(current_reduction_force)
);

// *** sim/i2c_host_model.sv ***
// Serial bus host model that reads and writes the register bank.
`timescale 1ns/1ps
module i2c_host_model (
	input wire sys_clk, // Clock.
	input wire sda_oe, // Bank pulls data low.
	output reg scl = 1'b1, // Serial clock.
	output wire sda // Data wire with pull-up.
);
	reg drv = 1'b1;
	// Open drain: low while either side pulls, otherwise the pull-up.
	assign sda = drv & ~sda_oe;
	// Waits n falling edges; every pin change lands on one.
	task t(input integer n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Start when s is one, stop when s is zero.
	task cond(input s);
		begin
			t(2);
			drv = s;
			t(2);
			scl = 1'b1;
			t(3);
			drv = ~s;
			t(3);
			scl = ~s;
		end
	endtask
	// One clock with data b; the wire is sampled mid-high.
	task bit_io(input b, output r);
		begin
			t(2);
			drv = b;
			t(2);
			scl = 1'b1;
			t(2);
			r = sda;
			t(2);
			scl = 1'b0;
		end
	endtask
	// Byte MSB first, then the ack bit m; a returns the sampled ack.
	task xfer(input [7:0] d, input m, output [7:0] q, output a);
		integer k;
		reg r;
		begin
			for (k = 7; k >= 0; k = k - 1) begin
				bit_io(d[k], r);
				q[k] = r;
			end
			bit_io(m, a);
		end
	endtask
	// Writes two bytes from pointer p; ok is one if all were acked.
	task wr(input [6:0] ad, input [7:0] p, d0, d1, output ok);
		reg [7:0] q;
		reg [3:0] n;
		begin
			cond(1'b1);
			xfer({ad, 1'b0}, 1'b1, q, n[0]);
			xfer(p, 1'b1, q, n[1]);
			xfer(p == 8'h02 ? d0 & 8'hfd : d0, 1'b1, q, n[2]);
			xfer(d1, 1'b1, q, n[3]);
			cond(1'b0);
			ok = ~|n;
		end
	endtask
	// Reads two bytes from pointer p, acking the first only.
	task rd(input [7:0] p, output [7:0] q0, q1, output ok);
		reg [7:0] q;
		reg [3:0] n;
		begin
			cond(1'b1);
			xfer(8'hd6, 1'b1, q, n[0]);
			xfer(p, 1'b1, q, n[1]);
			cond(1'b1);
			xfer(8'hd7, 1'b1, q, n[2]);
			xfer(8'hff, 1'b0, q0, n[3]);
			xfer(8'hff, 1'b1, q1, n[3]);
			cond(1'b0);
			ok = ~|n[2:0];
		end
	endtask
endmodule // i2c_host_model

// *** sim/charge_current_config_tb_top.sv ***
// Self-checking bench for the charge current register bank.
`timescale 1ns/1ps
module charge_current_config_tb_top;
	reg sys_clk = 1'b0;
	reg rstn = 1'b0;
	wire scl;
	wire sda;
	wire sda_oe;
	wire sda_out_w;
	reg ce = 1'b1;
	wire frc;
	wire [12:0] fast;
	wire [12:0] pre;
	wire [12:0] term;
	integer n_fail = 0;
	integer n_tests = 0;
	integer i;
	reg [7:0] q0;
	reg [7:0] q1;
	reg ok;
	reg [15:0] rows [0:5] = '{16'h0000, 16'hfcff, 16'h6111, 16'hfdf0,
		16'h050f, 16'h545a};
	charge_current_config dut (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.ce(ce),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out_w),
		.sda_oe(sda_oe),
		.fast_charge_current_limit(fast),
		.precharge_current_limit(pre),
		.termination_current_limit(term),
		.current_reduction_force(frc)
	);
	i2c_host_model host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl),
		.sda(sda));
	// Free-running 100 MHz clock.
	initial forever #5 sys_clk = ~sys_clk;
	// Fast limit from the register byte, cut to a fifth when forced.
	function [12:0] e_fast(input [7:0] r);
		begin
			e_fast = 13'h0200 + {r[7:2], 6'h00};
			if (r[0])
				e_fast = e_fast / 13'h0005;
		end
	endfunction
	// Compares a value and counts the result.
	task chk_val(input [47:0] nm, input [12:0] e, input [12:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("[FAIL] %0s expected %0d seen %0d", nm, e, g);
			end
		end
	endtask
	// Compares a single flag.
	task chk_bit(input [47:0] nm, input e, input g);
		chk_val(nm, {12'h000, e}, {12'h000, g});
	endtask
	// Prints the verdict and ends the run.
	task conclude;
		begin
			if (n_fail == 0 && n_tests > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// Reads both registers back and compares against a and b.
	task rd_chk(input [7:0] a, input [7:0] b);
		begin
			host.rd(8'h02, q0, q1, ok);
			chk_val("rd02", {5'h00, a}, {5'h00, q0});
			chk_val("rd03", {5'h00, b}, {5'h00, q1});
		end
	endtask
	// Main sequence: reset values, table of writes, then odd cases.
	initial begin
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		host.t(2);
		chk_val("fast", 13'h0800, fast);
		chk_val("pre", 13'h0100, pre);
		chk_val("term", 13'h0100, term);
		chk_bit("force", 1'b0, frc);
		chk_bit("sdaout", 1'b0, sda_out_w);
		rd_chk(8'h60, 8'h11);
		for (i = 0; i < 6; i = i + 1) begin
			host.wr(7'h6b, 8'h02, rows[i][15:8], rows[i][7:0], ok);
			chk_bit("ack", 1'b1, ok);
			chk_val("fast", e_fast(rows[i][15:8]), fast);
			chk_val("pre", (13'h0080 + {rows[i][7:4], 7'h00})
				>> rows[i][8], pre);
			chk_val("term", 13'h0080 + {rows[i][3:0], 7'h00}, term);
			chk_bit("force", rows[i][8], frc);
			rd_chk(rows[i][15:8], rows[i][7:0]);
		end
		host.wr(7'h6a, 8'h02, 8'h00, 8'h00, ok);
		chk_bit("nak", 1'b0, ok);
		chk_val("fast", e_fast(8'h54), fast);
		host.wr(7'h6b, 8'h06, 8'haa, 8'h55, ok);
		host.rd(8'h06, q0, q1, ok);
		chk_val("rd06", 13'h0000, {5'h00, q0 | q1});
		rd_chk(8'h54, 8'h5a);
		ce = 1'b0;
		host.wr(7'h6b, 8'h02, 8'hfd, 8'h00, ok);
		chk_bit("cenak", 1'b0, ok);
		chk_val("cefast", e_fast(8'h54), fast);
		ce = 1'b1;
		host.t(2);
		rd_chk(8'h54, 8'h5a);
		rstn = 1'b0;
		host.t(3);
		rstn = 1'b1;
		host.t(2);
		rd_chk(8'h60, 8'h11);
		conclude;
	end
endmodule // charge_current_config_tb_top
